// >>> design/motor_start_unit.sv
// Purpose: Motor start supervision with APB register access
// Assumes: Phase magnitudes come from on-chip logic on pclk
// Notes:   Trip contact closed means contactor may be energized
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "motor_start_consts.svh"
module motor_start_unit
	import motor_start_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] phase_a,
	input  wire logic [15:0] phase_b,
	input  wire logic [15:0] phase_c,
	input  wire logic        reverse_seq,
	input  wire logic        other_trip,
	input  wire logic        report_back_pin,
	input  wire logic        zero_speed_pin,
	input  wire logic [15:0] block_time,
	output logic             series_contact,
	output logic             trip,
	output logic             trip_cmd,
	output logic             transition_fail_trip,
	output logic             report_back_run_fail,
	output logic             report_back_start_fail,
	output logic             zero_speed_trip,
	output logic             reverse_rotation_trip,
	output logic             timed_transition,
	output logic             current_transition,
	output logic             restart_blocked,
	output logic             clear_timers,
	output logic             count_start,
	output logic [1:0]       op_state_code
);

	// ************************************************************
	// Tick and pin synchronisers
	// ************************************************************
	logic       tick;
	logic [1:0] pins_s;
	logic       rb_in;
	logic       zs_in;

	tick_gen #(.CYCLES(TICK_CYCLES)) u_tick
	(
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick)
	);

	sync2 #(.W(2)) u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({report_back_pin, zero_speed_pin}),
		.dout    (pins_s)
	);

	assign rb_in = pins_s[1];
	assign zs_in = pins_s[0];

	// ************************************************************
	// APB registers
	// ************************************************************
	logic [5:0]  ctrl_ff;
	logic [15:0] flc_ff;
	logic [15:0] transition_current_level_ff;
	logic [15:0] stop_current_level_ff;
	logic [15:0] transition_time_limit_ff;
	logic [15:0] lrt_ff;
	logic [15:0] rbt_ff;
	logic        restart_ff;
	logic [5:0]  nxt_ctrl;
	logic [15:0] nxt_flc;
	logic [15:0] nxt_transition_current_level;
	logic [15:0] nxt_stop_current_level;
	logic [15:0] nxt_transition_time_limit;
	logic [15:0] nxt_lrt;
	logic [15:0] nxt_rbt;
	logic        nxt_restart;
	logic        wr;
	logic        hit;
	logic [31:0] rd;
	logic [31:0] status_word;
	op_state_t   state_ff;

	assign wr      = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	always_comb
	begin
		nxt_ctrl    = ctrl_ff;
		nxt_flc     = flc_ff;
		nxt_transition_current_level    = transition_current_level_ff;
		nxt_stop_current_level    = stop_current_level_ff;
		nxt_transition_time_limit    = transition_time_limit_ff;
		nxt_lrt     = lrt_ff;
		nxt_rbt     = rbt_ff;
		nxt_restart = 1'b0;
		hit         = 1'b1;
		rd          = 32'h00000000;
		unique case (paddr)
			`REG_CTRL:   rd = {26'h0, ctrl_ff};
			`REG_FLC:    rd = {16'h0, flc_ff};
			`REG_TRANSITION_CURRENT_LEVEL:   rd = {16'h0, transition_current_level_ff};
			`REG_STOP_CURRENT_LEVEL:   rd = {16'h0, stop_current_level_ff};
			`REG_TRANSITION_TIME_LIMIT:   rd = {16'h0, transition_time_limit_ff};
			`REG_LRT:    rd = {16'h0, lrt_ff};
			`REG_RBT:    rd = {16'h0, rbt_ff};
			`REG_STATUS: rd = status_word;
			default:     hit = 1'b0;
		endcase
		if (wr && hit && paddr != `REG_STATUS)
		begin
			nxt_restart = 1'b1;
			unique case (paddr)
				`REG_CTRL: nxt_ctrl = pwdata[5:0];
				`REG_FLC:  nxt_flc  = pwdata[15:0];
				`REG_TRANSITION_CURRENT_LEVEL: nxt_transition_current_level = pwdata[15:0];
				`REG_STOP_CURRENT_LEVEL: nxt_stop_current_level = pwdata[15:0];
				`REG_TRANSITION_TIME_LIMIT: nxt_transition_time_limit = pwdata[15:0];
				`REG_LRT:  nxt_lrt  = pwdata[15:0];
				default:   nxt_rbt  = pwdata[15:0];
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff    <= `CTRL_RST;
			flc_ff     <= `CUR_RST;
			transition_current_level_ff    <= `CUR_RST;
			stop_current_level_ff    <= `CUR_RST;
			transition_time_limit_ff    <= `TIME_RST;
			lrt_ff     <= `TIME_RST;
			rbt_ff     <= `TIME_RST;
			restart_ff <= 1'b0;
			prdata     <= 32'h00000000;
		end
		else
		begin
			ctrl_ff    <= nxt_ctrl;
			flc_ff     <= nxt_flc;
			transition_current_level_ff    <= nxt_transition_current_level;
			stop_current_level_ff    <= nxt_stop_current_level;
			transition_time_limit_ff    <= nxt_transition_time_limit;
			lrt_ff     <= nxt_lrt;
			rbt_ff     <= nxt_rbt;
			restart_ff <= nxt_restart;
			prdata     <= (psel && !penable && !pwrite) ? rd : prdata;
		end
	end

	// ************************************************************
	// Current comparisons
	// ************************************************************
	logic [15:0] imax;
	logic [23:0] start_lvl;
	logic        above_start;
	logic        below_transition_current_level;
	logic        all_below_stop;
	rule_t       rule;

	assign imax = (phase_a > phase_b) ?
		((phase_a > phase_c) ? phase_a : phase_c) :
		((phase_b > phase_c) ? phase_b : phase_c);
	assign start_lvl = 24'(flc_ff * `START_PCT);
	assign above_start = 24'(imax * `PCT_FULL) > start_lvl;
	assign below_transition_current_level = imax < transition_current_level_ff;
	assign all_below_stop = phase_a < stop_current_level_ff && phase_b < stop_current_level_ff
		&& phase_c < stop_current_level_ff;
	assign rule = rule_t'(ctrl_ff[`CTRL_RULE_MSB:`CTRL_RULE_LSB]);

	// ************************************************************
	// State machine and timers
	// ************************************************************
	op_state_t   nxt_state;
	logic [15:0] t_ff;
	logic [15:0] nxt_t;
	logic [15:0] rbg_ff;
	logic [15:0] nxt_rbg;
	logic [15:0] blk_ff;
	logic [15:0] nxt_blk;
	logic        re_ff;
	logic        nxt_re;
	logic [6:0]  flags_ff;
	logic [6:0]  nxt_flags;
	logic [1:0]  ind_ff;
	logic [1:0]  nxt_ind;
	logic        t_exp;
	logic        zs_late;
	logic        rb_late;
	logic        rb_lost;
	logic        rev_due;
	logic        fault;

	assign t_exp   = t_ff >= transition_time_limit_ff;
	assign zs_late = ctrl_ff[`CTRL_ZSS_EN] && zs_in
		&& t_ff >= (lrt_ff >> 1);
	// Only at expiry; afterwards the glitch filter decides
	assign rb_late = ctrl_ff[`CTRL_INCOMPLETE_SEQUENCE_CHECK_EN] && !rb_in
		&& t_ff == rbt_ff;
	assign rb_lost = ctrl_ff[`CTRL_INCOMPLETE_SEQUENCE_CHECK_EN]
		&& rbg_ff >= 16'(`GLITCH_MS / `TICK_MS);
	assign rev_due = !ctrl_ff[`CTRL_REV_OK] && reverse_seq
		&& t_ff >= 16'(`REV_DELAY_MS / `TICK_MS);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_t     = (tick && t_ff != 16'hFFFF) ? t_ff + 16'h0001 : t_ff;
		nxt_rbg   = rbg_ff;
		nxt_blk   = (tick && blk_ff != 16'h0000) ?
			blk_ff - 16'h0001 : blk_ff;
		nxt_re    = re_ff;
		nxt_flags = flags_ff;
		nxt_ind   = ind_ff;
		fault     = 1'b0;
		if ((state_ff == ST_START || state_ff == ST_RUN)
			&& t_ff >= rbt_ff)
		begin
			if (rb_in)
				nxt_rbg = 16'h0000;
			else if (tick)
				nxt_rbg = rbg_ff + 16'h0001;
		end
		unique case (state_ff)
			ST_STOP:
			begin
				if (above_start)
				begin
					nxt_state = ST_START;
					nxt_t     = 16'h0000;
					nxt_rbg   = 16'h0000;
					nxt_ind   = 2'b00;
					nxt_flags = 7'h00;
					// Open switch at start trips from start state
					nxt_flags[2] = ctrl_ff[`CTRL_ZSS_EN] && !zs_in;
				end
			end
			ST_START:
			begin
				unique case (rule)
					TIMED_TRANSITION:
						if (t_exp)
							nxt_ind = 2'b10;
					CURRENT_TRANSITION:
						if (below_transition_current_level)
							nxt_ind = 2'b01;
						else if (t_exp)
							fault = 1'b1;
					EITHER_TRANSITION:
						if (below_transition_current_level || t_exp)
							nxt_ind = {t_exp, below_transition_current_level};
					COMBINED_TRANSITION:
						if (below_transition_current_level && !t_exp)
							nxt_ind = 2'b11;
						else if (t_exp)
							fault = 1'b1;
				endcase
				if (fault)
				begin
					nxt_state    = ST_TRIP;
					nxt_flags[0] = 1'b1;
				end
				else if (nxt_ind != 2'b00)
					nxt_state = ST_RUN;
				else if (all_below_stop)
					nxt_state = ST_STOP;
			end
			ST_RUN:
			begin
				if (all_below_stop)
				begin
					nxt_state = ST_STOP;
					nxt_blk   = block_time;
				end
			end
			default:
			begin
				if (all_below_stop)
				begin
					nxt_state = ST_STOP;
					nxt_blk   = block_time;
				end
			end
		endcase
		if (state_ff == ST_START || state_ff == ST_RUN)
		begin
			if (rb_late || rb_lost)
			begin
				nxt_state = ST_TRIP;
				nxt_flags[1] = !ctrl_ff[`CTRL_INCOMPLETE_SEQUENCE_CHECK_SEL];
				nxt_flags[3] = ctrl_ff[`CTRL_INCOMPLETE_SEQUENCE_CHECK_SEL];
			end
			if (zs_late || (state_ff == ST_START && flags_ff[2]))
			begin
				nxt_state    = ST_TRIP;
				nxt_flags[2] = 1'b1;
			end
			if (rev_due)
			begin
				nxt_state    = ST_TRIP;
				nxt_flags[4] = 1'b1;
			end
			if (other_trip)
			begin
				nxt_state    = ST_TRIP;
				nxt_flags[5] = 1'b1;
			end
		end
		if (restart_ff)
		begin
			nxt_state = ST_STOP;
			nxt_re    = 1'b1;
			nxt_t     = 16'h0000;
			nxt_rbg   = 16'h0000;
			nxt_blk   = 16'h0000;
		end
		else if (state_ff == ST_RUN || nxt_state == ST_STOP)
			nxt_re = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ST_STOP;
			t_ff     <= 16'h0000;
			rbg_ff   <= 16'h0000;
			blk_ff   <= 16'h0000;
			re_ff    <= 1'b0;
			flags_ff <= 7'h00;
			ind_ff   <= 2'b00;
		end
		else
		begin
			state_ff <= nxt_state;
			t_ff     <= nxt_t;
			rbg_ff   <= nxt_rbg;
			blk_ff   <= nxt_blk;
			re_ff    <= nxt_re;
			flags_ff <= nxt_flags;
			ind_ff   <= nxt_ind;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign series_contact = state_ff != ST_TRIP;
	assign trip           = state_ff == ST_TRIP;
	assign trip_cmd       = state_ff == ST_TRIP;
	assign transition_fail_trip   = flags_ff[0];
	assign report_back_run_fail   = flags_ff[1];
	assign zero_speed_trip        = flags_ff[2];
	assign report_back_start_fail = flags_ff[3];
	assign reverse_rotation_trip  = flags_ff[4];
	assign timed_transition   = state_ff == ST_RUN && ind_ff[1];
	assign current_transition = state_ff == ST_RUN && ind_ff[0];
	assign restart_blocked    = blk_ff != 16'h0000;
	assign clear_timers       = restart_ff;
	assign count_start = state_ff == ST_STOP && nxt_state == ST_START
		&& !re_ff;
	assign op_state_code = {state_ff[2] | state_ff[3],
		state_ff[1] | state_ff[3]};
	assign status_word = {blk_ff, 3'h0, flags_ff, ind_ff,
		2'h0, op_state_code};

endmodule

// >>> design/sync2.sv
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are slow levels
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
module sync2
#(
	parameter int W = 4
)
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
		end
		else
		begin
			s1_ff <= din;
			s2_ff <= s1_ff;
		end
	end

	assign dout = s2_ff;

endmodule

// >>> design/tick_gen.sv
// Purpose: Fixed-rate tick from pclk
// Assumes: Count fits in 32 bits
// Notes:   One-cycle pulse every CYCLES clocks
`timescale 1ns/10ps
module tick_gen
#(
	parameter int CYCLES = 200000
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      tick
);

	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic        tick_ff;
	logic        nxt_tick;

	always_comb
	begin
		nxt_tick = 1'b0;
		nxt_cnt  = cnt_ff + 32'h00000001;
		if (cnt_ff >= 32'(CYCLES - 1))
		begin
			nxt_cnt  = 32'h00000000;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_ff  <= 32'h00000000;
			tick_ff <= 1'b0;
		end
		else
		begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;

endmodule

// >>> inc/motor_start_consts.svh
// Purpose: Constants for the motor start supervision block
// Assumes: 16-bit current magnitudes, 1 ms tick derived from pclk
// Notes:   Register map is APB, one 32-bit word per register
`ifndef MOTOR_START_CONSTS_SVH
`define MOTOR_START_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_CTRL         12'h000
`define REG_FLC          12'h004
`define REG_TRANSITION_CURRENT_LEVEL         12'h008
`define REG_STOP_CURRENT_LEVEL         12'h00C
`define REG_TRANSITION_TIME_LIMIT         12'h010
`define REG_LRT          12'h014
`define REG_RBT          12'h018
`define REG_STATUS       12'h01C

// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_RULE_LSB    0
`define CTRL_RULE_MSB    1
`define CTRL_INCOMPLETE_SEQUENCE_CHECK_EN     2
`define CTRL_INCOMPLETE_SEQUENCE_CHECK_SEL    3
`define CTRL_ZSS_EN      4
`define CTRL_REV_OK      5

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define CTRL_RST         6'h00
`define CUR_RST          16'h0000
`define TIME_RST         16'h0000
`define START_PCT        30
`define PCT_FULL         100
`define TICK_MS          1
`define CLK_MHZ          200
`define TICK_CYCLES      (`TICK_MS * `CLK_MHZ * 1000)
`define GLITCH_MS        500
`define REV_DELAY_MS     100

`endif

// >>> inc/motor_start_pkg.sv
// Purpose: Types for the motor start supervision block
// Assumes: Constants come from motor_start_consts.svh
// Notes:   States are one-hot
package motor_start_pkg;

	typedef enum logic [3:0]
	{
		ST_STOP  = 4'h1,
		ST_START = 4'h2,
		ST_RUN   = 4'h4,
		ST_TRIP  = 4'h8
	} op_state_t;

	typedef enum logic [1:0]
	{
		TIMED_TRANSITION    = 2'h0,
		CURRENT_TRANSITION  = 2'h1,
		EITHER_TRANSITION   = 2'h2,
		COMBINED_TRANSITION = 2'h3
	} rule_t;

endpackage

// >>> test/motor_plant.sv
// Purpose: Contactor, motor currents and process contacts
// Assumes: Contactor follows the series contact at once
// Notes:   zs_mode 0 normal, 1 stuck closed, 2 stuck open
`timescale 1ns/10ps
module motor_plant
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        series_contact,
	input  wire logic [15:0] load,
	input  wire logic [1:0]  zs_mode,
	input  wire logic        rb_ok,
	output logic      [15:0] phase_a,
	output logic      [15:0] phase_b,
	output logic      [15:0] phase_c,
	output logic             report_back_pin,
	output logic             zero_speed_pin
);
	// ********************
	// Plant
	// ********************
	logic [15:0] cur;
	logic [7:0]  spin_ff;
	logic [7:0]  nxt_spin;

	// Open contact drops the contactor, so current ceases
	assign cur = series_contact ? load : 16'h0000;
	assign phase_a = cur >> 1;
	assign phase_b = cur;
	assign phase_c = cur >> 2;
	assign report_back_pin = rb_ok && (cur != 16'h0000);
	// Switch closed at rest, opens once the rotor spins
	assign zero_speed_pin = (zs_mode == 2'h1) ||
		(zs_mode == 2'h0 && spin_ff != 8'h08);

	always_comb
	begin
		nxt_spin = spin_ff;
		if (cur == 16'h0000)
			nxt_spin = 8'h00;
		else if (spin_ff != 8'h08)
			nxt_spin = spin_ff + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			spin_ff <= 8'h00;
		else
			spin_ff <= nxt_spin;
	end
endmodule

// >>> test/motor_start_unit_properties.sv
// Purpose: Port checks for motor_start_unit
// Assumes: One pclk domain, presetn async low
// Notes:   Bound into every motor_start_unit
`timescale 1ns/10ps
module motor_start_props
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [15:0] phase_a,
	input wire logic [15:0] phase_b,
	input wire logic [15:0] phase_c,
	input wire logic        other_trip,
	input wire logic        series_contact,
	input wire logic        trip,
	input wire logic        trip_cmd,
	input wire logic        reverse_rotation_trip,
	input wire logic        timed_transition,
	input wire logic        current_transition,
	input wire logic        clear_timers,
	input wire logic [1:0]  op_state_code
);
	// ********************
	// Checks
	// ********************
	logic [1:0] st;

	assign st = op_state_code;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	contact_open_a: assert property (
		series_contact == (st != 2'h3)) else $error("contact wrong");
	trip_pair_a: assert property (
		trip == trip_cmd && trip == (st == 2'h3)) else $error("trip out");
	stop_exit_a: assert property (
		$past(st) == 2'h0 && st != 2'h0 |-> st == 2'h1)
		else $error("bad exit from stop");
	run_entry_a: assert property (
		$changed(st) && st == 2'h2 |-> $past(st) == 2'h1)
		else $error("bad entry to run");
	other_trip_a: assert property (
		other_trip && st inside {2'h1, 2'h2} |-> ##[1:3] st == 2'h3)
		else $error("other trip ignored");
	trip_release_a: assert property (
		st == 2'h3 && (phase_a | phase_b | phase_c) == 16'h0000
		|-> ##[1:3] st == 2'h0) else $error("trip held");
	run_flags_a: assert property (
		(timed_transition || current_transition) == (st == 2'h2))
		else $error("run flag wrong");
	restart_a: assert property (
		psel && penable && pwrite && paddr <= 12'h018
		&& paddr[1:0] == 2'h0 |=> clear_timers ##1 st == 2'h0)
		else $error("no restart");
	rev_trip_a: assert property (
		$rose(reverse_rotation_trip) |-> ##[0:2] trip_cmd)
		else $error("reverse trip late");

	cover property (st == 2'h2 && timed_transition);
	cover property (st == 2'h2 && current_transition);
	cover property ($rose(reverse_rotation_trip));
endmodule

bind motor_start_unit motor_start_props props
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .phase_a,
	.phase_b, .phase_c, .other_trip, .series_contact, .trip,
	.trip_cmd, .reverse_rotation_trip, .timed_transition,
	.current_transition, .clear_timers, .op_state_code
);

// >>> test/motor_start_unit_tb.sv
// Purpose: Self-checking bench for motor_start_unit
// Assumes: TICK_CYCLES of 4, so one tick is 20 ns
// Notes:   motor_plant supplies currents and contacts
`timescale 1ns/10ps
`include "motor_start_consts.svh"
module motor_start_unit_tb import motor_start_pkg::*;;
	// ********************
	// Bench
	// ********************
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        reverse_seq, other_trip, rb_ok, cs_seen, seen0, err;
	logic        report_back_pin, zero_speed_pin, series_contact, trip;
	logic        trip_cmd, transition_fail_trip, report_back_run_fail;
	logic        report_back_start_fail, zero_speed_trip, count_start;
	logic        reverse_rotation_trip, timed_transition, clear_timers;
	logic        current_transition, restart_blocked;
	logic [1:0]  zs_mode, op_state_code;
	logic [11:0] paddr;
	logic [15:0] phase_a, phase_b, phase_c, load, block_time;
	logic [31:0] pwdata, prdata, rd;
	int          num_errors = 0;
	int          comparisons = 0;
	int          n;

	motor_start_unit #(.TICK_CYCLES(4)) uut
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .phase_a, .phase_b, .phase_c,
		.reverse_seq, .other_trip, .report_back_pin, .zero_speed_pin,
		.block_time, .series_contact, .trip, .trip_cmd,
		.transition_fail_trip, .report_back_run_fail,
		.report_back_start_fail, .zero_speed_trip,
		.reverse_rotation_trip, .timed_transition, .current_transition,
		.restart_blocked, .clear_timers, .count_start, .op_state_code
	);

	motor_plant plant
	(
		.pclk, .presetn, .series_contact, .load, .zs_mode, .rb_ok,
		.phase_a, .phase_b, .phase_c, .report_back_pin, .zero_speed_pin
	);

	always #2.5 pclk = ~pclk;

	always @(posedge pclk)
	begin
		if (count_start === 1'b1)
			cs_seen <= 1'b1;
		if (op_state_code === 2'h0)
			seen0 <= 1'b1;
	end

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_st(logic [1:0] s, int lim);
		n = 0;
		while (op_state_code !== s && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		chk("state", op_state_code, s);
	endtask

	task automatic go(logic [31:0] c, logic [15:0] lv);
		xfer(1'b1, `REG_CTRL, c);
		load <= lv;
	endtask

	task automatic halt();
		load <= 16'h0000;
		wait_st(2'h0, 20);
	endtask

	task automatic s_reset();
		chk("contact", series_contact, 1'b1);
		xfer(1'b0, `REG_TRANSITION_TIME_LIMIT, 32'h00000000);
		chk("transition_time_limit", rd, 32'h00000000);
		xfer(1'b0, 12'h020, 32'h00000000);
		chk("slverr", err, 1'b1);
		xfer(1'b1, `REG_FLC, 32'h00000064);
		xfer(1'b1, `REG_TRANSITION_CURRENT_LEVEL, 32'h00000032);
		xfer(1'b1, `REG_STOP_CURRENT_LEVEL, 32'h0000000A);
		xfer(1'b1, `REG_TRANSITION_TIME_LIMIT, 32'h00000014);
		xfer(1'b1, `REG_LRT, 32'h0000001E);
		xfer(1'b1, `REG_RBT, 32'h00000014);
		xfer(1'b0, `REG_TRANSITION_CURRENT_LEVEL, 32'h00000000);
		chk("transition_current_level", rd, 32'h00000032);
	endtask

	task automatic s_timed();
		go(32'h00000000, 16'h001E);
		repeat (20) @(posedge pclk);
		chk("idle", op_state_code, 2'h0);
		load <= 16'h001F;
		wait_st(2'h1, 10);
		wait_st(2'h2, 200);
		chk("time", n >= 70 && n <= 90, 1'b1);
		@(posedge pclk);
		chk("ind", {timed_transition, current_transition}, 2'h2);
		halt();
		chk("blocked", restart_blocked, 1'b1);
		cs_seen <= 1'b0;
		load <= 16'h00C8;
		wait_st(2'h1, 10);
		chk("count", cs_seen, 1'b1);
		halt();
	endtask

	task automatic s_either();
		go(32'h00000002, 16'h00C8);
		wait_st(2'h1, 10);
		load <= 16'h0028;
		wait_st(2'h2, 20);
		@(posedge pclk);
		chk("ind", {timed_transition, current_transition}, 2'h1);
		halt();
	endtask

	task automatic s_fail();
		go(32'h00000001, 16'h00C8);
		wait_st(2'h1, 10);
		wait_st(2'h3, 200);
		load <= 16'h0000;
		chk("open", series_contact, 1'b0);
		chk("late", n >= 70, 1'b1);
		@(posedge pclk);
		chk("fail", transition_fail_trip, 1'b1);
		wait_st(2'h0, 10);
	endtask

	task automatic s_combined();
		go(32'h00000003, 16'h00C8);
		wait_st(2'h1, 10);
		load <= 16'h0028;
		wait_st(2'h2, 200);
		other_trip <= 1'b1;
		wait_st(2'h3, 5);
		other_trip <= 1'b0;
		halt();
	endtask

	task automatic s_restart();
		go(32'h00000000, 16'h00C8);
		wait_st(2'h2, 200);
		cs_seen <= 1'b0;
		seen0 <= 1'b0;
		xfer(1'b1, `REG_STOP_CURRENT_LEVEL, 32'h0000000A);
		wait_st(2'h1, 10);
		wait_st(2'h2, 200);
		chk("stop", seen0, 1'b1);
		chk("timer", n >= 70, 1'b1);
		chk("count", cs_seen, 1'b0);
		halt();
	endtask

	task automatic s_zero();
		zs_mode <= 2'h2;
		go(32'h00000010, 16'h00C8);
		wait_st(2'h3, 10);
		halt();
		zs_mode <= 2'h1;
		repeat (4) @(posedge pclk);
		load <= 16'h00C8;
		wait_st(2'h1, 10);
		wait_st(2'h3, 100);
		chk("half", n >= 50, 1'b1);
		@(posedge pclk);
		chk("zs", zero_speed_trip, 1'b1);
		halt();
		zs_mode <= 2'h0;
	endtask

	task automatic s_reverse();
		reverse_seq <= 1'b1;
		go(32'h00000000, 16'h00C8);
		wait_st(2'h1, 10);
		wait_st(2'h3, 500);
		chk("delay", n >= 385 && n <= 410, 1'b1);
		@(posedge pclk);
		chk("rev", reverse_rotation_trip, 1'b1);
		reverse_seq <= 1'b0;
		halt();
	endtask

	task automatic s_rb();
		rb_ok <= 1'b0;
		go(32'h0000000C, 16'h00C8);
		wait_st(2'h1, 10);
		wait_st(2'h3, 200);
		@(posedge pclk);
		chk("rb", {report_back_run_fail, report_back_start_fail}, 2'h1);
		rb_ok <= 1'b1;
		halt();
	endtask

	task automatic s_glitch();
		go(32'h00000004, 16'h00C8);
		wait_st(2'h2, 200);
		rb_ok <= 1'b0;
		repeat (100) @(posedge pclk);
		rb_ok <= 1'b1;
		repeat (20) @(posedge pclk);
		chk("short", op_state_code, 2'h2);
		rb_ok <= 1'b0;
		wait_st(2'h3, 2100);
		chk("long", n >= 1990 && n <= 2010, 1'b1);
		@(posedge pclk);
		chk("seq", {report_back_run_fail, report_back_start_fail},
			2'h2);
		rb_ok <= 1'b1;
		halt();
	endtask

	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		{pclk, psel, penable, pwrite, reverse_seq, other_trip} = '0;
		{cs_seen, seen0, paddr, pwdata, load, zs_mode} = '0;
		presetn = 1'b0;
		rb_ok = 1'b1;
		block_time = 16'h0005;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset", op_state_code, 2'h0);
		s_reset();
		s_timed();
		s_either();
		s_fail();
		s_combined();
		s_restart();
		s_zero();
		s_reverse();
		s_rb();
		s_glitch();
		summarize();
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		summarize();
	end
endmodule
